// *** verilog/port_control_registers.sv ***
// Per-port control register pair with its control outputs.
// Assumes host strobes, global sources and line data all on core_clk.
//
// Contract
// - Bit 15 set disables transmit cell nibble alignment.
// - Three-bit payload AIS select chooses when receive all-ones is forced.
// - Two-bit line AIS select chooses transmitted AIS, overriding framer.
// - Bit 9 enables the bit error test; clear powers it down.
// - Receive data reaches the processor regardless of test enable.
// - Bit 8 routes HDLC to PLCP framers only in PLCP modes.
// - Rising manual insert bit with port source inserts errors.
// - Bit 6 picks port bit or global source for error insertion.
// - Bit 4 picks port bit or global source for monitor updates.
// - Rising update bit in port mode loads counts and clears counters.
// - Update bit held until done rises; done clears when bit drops.
// - Power-down bit stops port clocks; set after reset.
// - Data-path reset forces defaults, held 100ns, reads 1 after reset.
// - Port reset ORs with pin and global reset, reloads reset values into all but itself.
// - Transmit line output enable; clear forces tx_line_clk_out, tx_pos_out and tx_neg_out low.
// - Driver tri-state bit; no effect while line interface is down.
// - Cell verify count is six when clear, eight when set.
// - In PLCP modes bit 7 moves delineation to the PLCP framer.
// - In POS bus mode without PLCP bit 6 picks cell or packet.
// - Three-bit interface mode; reset code disables line interface.
// - Six-bit framing mode field with reset code zero.
//
// Local design decision: strobed register access.
`timescale 1ns/1ps
`default_nettype none

module port_control_registers
	import port_ctrl_pkg::*;
(
	input  wire logic              core_clk,
	input  wire logic              rst_n,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [DATA_W-1:0] wr_data,
	input  wire logic              wr_en,
	input  wire logic              rd_en,
	output logic      [DATA_W-1:0] rd_data,
	input  wire logic              global_reset,
	input  wire logic              global_err_insert_src,
	input  wire logic              global_perf_update_src,
	input  wire logic              plcp_mode,
	input  wire logic              pos_bus_mode,
	input  wire logic              rx_fifo_reset,
	input  wire logic              tx_line_clk_in,
	input  wire logic              tx_pos_in,
	input  wire logic              tx_neg_in,
	input  wire logic              tx_liu_pos_in,
	input  wire logic              tx_liu_neg_in,
	output logic                   nibble_align_off,
	output logic      [2:0]        payload_ais_sel,
	output logic      [1:0]        line_ais_sel,
	output logic                   bit_error_test_on,
	output logic                   hdlc_to_plcp,
	output logic                   err_insert_pulse,
	output logic                   perf_update_pulse,
	output logic                   port_clk_en,
	output logic                   datapath_reset_out,
	output logic                   port_regs_reset,
	output logic                   rx_to_cell_proc,
	output logic                   tx_line_clk_out,
	output logic                   tx_pos_out,
	output logic                   tx_neg_out,
	output logic                   tx_line_pos_out,
	output logic                   tx_line_pos_oe,
	output logic                   tx_line_neg_out,
	output logic                   tx_line_neg_oe,
	output logic                   rx_monitor_gain,
	output logic                   tx_line_buildout,
	output logic      [3:0]        cell_verify_count,
	output logic                   delin_in_plcp,
	output logic                   cell_processing,
	output logic      [2:0]        port_iface_mode,
	output logic      [5:0]        framing_mode_sel
);

	// ****************************************
	// Register state
	// ****************************************
	logic [15:0] cr1_reg;
	logic [15:0] cr1_next;
	logic [15:0] cr2_reg;
	logic [15:0] cr2_next;
	logic        perf_update_done_reg;
	logic        err_trig_prev_reg;
	logic        perf_trig_prev_reg;
	logic        g_err_prev_reg;
	logic        g_perf_prev_reg;
	logic [5:0]  dp_hold_reg;
	logic        soft_rst;
	logic        sw_perf_rise;
	logic        liu_on;

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] ofs);
		hit = (a == ofs);
	endfunction

	// Pin reset acts asynchronously; software and global resets act on the clock
	assign soft_rst = cr1_reg[PORT_RESET_BIT] | global_reset;
	assign sw_perf_rise = cr1_reg[PERF_UPDATE_TRIG_BIT] & ~perf_trig_prev_reg
		& ~cr1_reg[PERF_UPDATE_SOURCE_BIT];
	assign liu_on = ~cr1_reg[PORT_POWER_DOWN_BIT]
		& (cr2_reg[PORT_IFACE_MODE_HI:PORT_IFACE_MODE_LO] != IFACE_MODE_OFF);

	// ****************************************
	// Register writes
	// ****************************************
	always_comb begin
		cr1_next = cr1_reg;
		cr2_next = cr2_reg;
		if (wr_en && hit(addr, PORT_CONTROL_ONE_OFS)) begin
			cr1_next = wr_data & CR1_WMASK;
		end
		if (wr_en && hit(addr, PORT_CONTROL_TWO_OFS)) begin
			cr2_next = wr_data;
		end
		if (soft_rst) begin
			// The port reset bit survives its own reset so software can release it
			cr1_next = CR1_RESET | (cr1_next & 16'h0001);
			cr2_next = CR2_RESET;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cr1_reg <= CR1_RESET;
			cr2_reg <= CR2_RESET;
		end else begin
			cr1_reg <= cr1_next;
			cr2_reg <= cr2_next;
		end
	end

	// ****************************************
	// Read port
	// ****************************************
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data <= 16'h0000;
		end else if (rd_en) begin
			if (hit(addr, PORT_CONTROL_ONE_OFS)) begin
				rd_data <= cr1_reg;
			end else if (hit(addr, PORT_CONTROL_TWO_OFS)) begin
				rd_data <= cr2_reg;
			end else if (hit(addr, PORT_STATUS_OFS)) begin
				rd_data <= 16'(perf_update_done_reg) << PERF_UPDATE_DONE_BIT;
			end else begin
				rd_data <= 16'h0000;
			end
		end else begin
			rd_data <= 16'h0000;
		end
	end

	// ****************************************
	// Error insertion and monitor updates
	// ****************************************
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			err_trig_prev_reg  <= 1'b0;
			perf_trig_prev_reg <= 1'b0;
			g_err_prev_reg     <= 1'b0;
			g_perf_prev_reg    <= 1'b0;
			err_insert_pulse   <= 1'b0;
			perf_update_pulse  <= 1'b0;
		end else begin
			err_trig_prev_reg  <= cr1_reg[MANUAL_ERR_INSERT_BIT];
			perf_trig_prev_reg <= cr1_reg[PERF_UPDATE_TRIG_BIT];
			g_err_prev_reg     <= global_err_insert_src;
			g_perf_prev_reg    <= global_perf_update_src;
			if (cr1_reg[ERR_INSERT_SOURCE_BIT]) begin
				err_insert_pulse <= global_err_insert_src & ~g_err_prev_reg;
			end else begin
				err_insert_pulse <= cr1_reg[MANUAL_ERR_INSERT_BIT]
					& ~err_trig_prev_reg;
			end
			if (cr1_reg[PERF_UPDATE_SOURCE_BIT]) begin
				perf_update_pulse <= global_perf_update_src & ~g_perf_prev_reg;
			end else begin
				perf_update_pulse <= sw_perf_rise;
			end
		end
	end

	// Done status: a new update beats the clear in the same cycle
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			perf_update_done_reg <= 1'b0;
		end else if (sw_perf_rise) begin
			perf_update_done_reg <= 1'b1;
		end else if (soft_rst || !cr1_reg[PERF_UPDATE_TRIG_BIT]) begin
			perf_update_done_reg <= 1'b0;
		end
	end

	// ****************************************
	// Resets and power
	// ****************************************
	// Stretch keeps the data path in reset for the minimum time even on a short pulse
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			dp_hold_reg        <= 6'(RESET_HOLD_CYCLES);
			datapath_reset_out <= 1'b1;
			port_regs_reset    <= 1'b1;
			port_clk_en        <= 1'b0;
		end else begin
			if (cr1_reg[DATAPATH_RESET_BIT] || soft_rst) begin
				dp_hold_reg <= 6'(RESET_HOLD_CYCLES);
			end else if (dp_hold_reg != 6'h00) begin
				dp_hold_reg <= dp_hold_reg - 6'h01;
			end
			datapath_reset_out <= cr1_reg[DATAPATH_RESET_BIT] | soft_rst
				| (dp_hold_reg > 6'h01);
			port_regs_reset    <= soft_rst;
			port_clk_en        <= ~cr1_reg[PORT_POWER_DOWN_BIT];
		end
	end

	// ****************************************
	// Framer and processor controls
	// ****************************************
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			nibble_align_off  <= 1'b0;
			payload_ais_sel   <= 3'h0;
			line_ais_sel      <= 2'h0;
			bit_error_test_on <= 1'b0;
			hdlc_to_plcp      <= 1'b0;
			rx_to_cell_proc   <= 1'b0;
			cell_verify_count <= CELL_VERIFY_SIX;
			delin_in_plcp     <= 1'b0;
			cell_processing   <= 1'b0;
			port_iface_mode   <= 3'h0;
			framing_mode_sel  <= 6'h00;
			rx_monitor_gain   <= 1'b0;
			tx_line_buildout  <= 1'b0;
		end else begin
			nibble_align_off  <= cr1_reg[NIBBLE_ALIGN_OFF_BIT];
			payload_ais_sel   <= cr1_reg[PAYLOAD_AIS_HI:PAYLOAD_AIS_LO];
			line_ais_sel      <= cr1_reg[LINE_AIS_HI:LINE_AIS_LO];
			bit_error_test_on <= cr1_reg[BIT_ERROR_TEST_ON_BIT];
			hdlc_to_plcp      <= cr1_reg[HDLC_ROUTE_SEL_BIT] & plcp_mode;
			// Receive flow ignores the test enable; only the FIFO reset blocks it
			rx_to_cell_proc   <= ~rx_fifo_reset;
			cell_verify_count <= cr2_reg[CELL_VERIFY_EIGHT_BIT]
				? CELL_VERIFY_EIGHT : CELL_VERIFY_SIX;
			delin_in_plcp     <= cr2_reg[CELL_DELIN_IN_PLCP_BIT] & plcp_mode;
			cell_processing   <= ~pos_bus_mode | plcp_mode
				| cr2_reg[CELL_PROC_SELECT_BIT];
			port_iface_mode   <= cr2_reg[PORT_IFACE_MODE_HI:PORT_IFACE_MODE_LO];
			framing_mode_sel  <= cr2_reg[FRAMING_MODE_HI:FRAMING_MODE_LO];
			rx_monitor_gain   <= cr2_reg[RX_MONITOR_GAIN_BIT];
			tx_line_buildout  <= cr2_reg[TX_LINE_BUILDOUT_BIT];
		end
	end

	// ****************************************
	// Transmit line outputs
	// ****************************************
	// Line data gains one register stage; framers must allow for that latency
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_line_clk_out <= 1'b0;
			tx_pos_out      <= 1'b0;
			tx_neg_out      <= 1'b0;
			tx_line_pos_out <= 1'b0;
			tx_line_neg_out <= 1'b0;
			tx_line_pos_oe  <= 1'b0;
			tx_line_neg_oe  <= 1'b0;
		end else begin
			tx_line_clk_out <= tx_line_clk_in & cr2_reg[TX_LINE_OUT_ON_BIT];
			tx_pos_out      <= tx_pos_in & cr2_reg[TX_LINE_OUT_ON_BIT];
			tx_neg_out      <= tx_neg_in & cr2_reg[TX_LINE_OUT_ON_BIT];
			tx_line_pos_out <= tx_liu_pos_in & liu_on;
			tx_line_neg_out <= tx_liu_neg_in & liu_on;
			tx_line_pos_oe  <= liu_on & ~cr2_reg[TX_DRIVER_HIZ_BIT];
			tx_line_neg_oe  <= liu_on & ~cr2_reg[TX_DRIVER_HIZ_BIT];
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	logic [6:0] dp_on_cnt;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			dp_on_cnt <= 7'h00;
		end else if (datapath_reset_out) begin
			if (dp_on_cnt != 7'h7F) begin
				dp_on_cnt <= dp_on_cnt + 7'h01;
			end
		end else begin
			dp_on_cnt <= 7'h00;
		end
	end

	a_err_sw_edge: assert property (
		!cr1_reg[ERR_INSERT_SOURCE_BIT] && cr1_reg[MANUAL_ERR_INSERT_BIT]
		&& !err_trig_prev_reg |=> err_insert_pulse)
		else $error("manual error insert edge missed");
	a_err_global_src: assert property (
		cr1_reg[ERR_INSERT_SOURCE_BIT] && !(global_err_insert_src && !g_err_prev_reg)
		|=> !err_insert_pulse)
		else $error("error insert without global edge");
	a_perf_global_src: assert property (
		cr1_reg[PERF_UPDATE_SOURCE_BIT] && $rose(global_perf_update_src)
		|=> perf_update_pulse)
		else $error("global update edge missed");
	a_perf_done_seq: assert property (
		sw_perf_rise |=> perf_update_pulse && perf_update_done_reg)
		else $error("update pulse or done missing");
	a_done_clear: assert property (
		perf_update_done_reg && !cr1_reg[PERF_UPDATE_TRIG_BIT] |=> !perf_update_done_reg)
		else $error("done not cleared after trigger low");
	a_power_clock: assert property (
		cr1_reg[PORT_POWER_DOWN_BIT] |=> !port_clk_en)
		else $error("port clock runs in power-down");
	a_dp_hold_time: assert property (
		$fell(datapath_reset_out) |-> $past(dp_on_cnt) >= 7'(RESET_HOLD_CYCLES - 1))
		else $error("data-path reset too short");
	a_soft_reset: assert property (
		soft_rst |=> cr1_reg[15:1] == CR1_RESET[15:1] && cr2_reg == CR2_RESET)
		else $error("soft reset left registers changed");
	a_tx_forced_low: assert property (
		!cr2_reg[TX_LINE_OUT_ON_BIT] |=> !tx_line_clk_out && !tx_pos_out && !tx_neg_out)
		else $error("line outputs not forced low");
	a_driver_hiz: assert property (
		cr2_reg[TX_DRIVER_HIZ_BIT] || !liu_on |=> !tx_line_pos_oe && !tx_line_neg_oe)
		else $error("driver enabled while tri-stated");
	a_verify_count: assert property (
		##1 cell_verify_count == ($past(cr2_reg[CELL_VERIFY_EIGHT_BIT])
		? CELL_VERIFY_EIGHT : CELL_VERIFY_SIX))
		else $error("cell verify count wrong");
	a_hdlc_route: assert property (
		!plcp_mode |=> !hdlc_to_plcp)
		else $error("HDLC routed to PLCP outside PLCP");
	a_read_latency: assert property (
		rd_en && hit(addr, PORT_CONTROL_TWO_OFS) |=> rd_data == $past(cr2_reg))
		else $error("read data wrong");

	// Routing outputs follow the registers and mode inputs one cycle later
	a_rx_flow: assert property (
		!rx_fifo_reset |=> rx_to_cell_proc)
		else $error("receive flow blocked");
	a_nibble_align: assert property (
		##1 nibble_align_off == $past(cr1_reg[NIBBLE_ALIGN_OFF_BIT]))
		else $error("nibble align control wrong");
	a_bert_enable: assert property (
		cr1_reg[BIT_ERROR_TEST_ON_BIT] |=> bit_error_test_on)
		else $error("test logic enable lost");
	a_cell_proc_mode: assert property (
		plcp_mode || !pos_bus_mode |=> cell_processing)
		else $error("packet processing chosen outside packet bus mode");
	a_delin_plcp: assert property (
		!plcp_mode |=> !delin_in_plcp)
		else $error("delineation moved outside PLCP");
	a_iface_mode: assert property (
		##1 port_iface_mode == $past(cr2_reg[PORT_IFACE_MODE_HI:PORT_IFACE_MODE_LO]))
		else $error("interface mode export wrong");

	c_perf_handshake: cover property (
		sw_perf_rise ##1 perf_update_done_reg ##[1:20] !perf_update_done_reg);
	c_err_insert: cover property (err_insert_pulse);
	c_soft_reset: cover property ($fell(soft_rst) ##[1:30] $fell(datapath_reset_out));
	c_global_update: cover property (cr1_reg[PERF_UPDATE_SOURCE_BIT] && perf_update_pulse);
	c_line_driving: cover property (tx_line_pos_oe && tx_line_clk_out);

endmodule // port_control_registers

`default_nettype wire

// *** inc/port_ctrl_pkg.sv ***
// Constants for the per-port control register pair.
// Assumes a 16-bit host register port and one 200 MHz core clock.
package port_ctrl_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam int          ADDR_W               = 12;
	localparam int          DATA_W               = 16;
	localparam logic [11:0] PORT_CONTROL_ONE_OFS = 12'h040;
	localparam logic [11:0] PORT_CONTROL_TWO_OFS = 12'h042;
	localparam logic [11:0] PORT_STATUS_OFS      = 12'h052;

	// Reset values: power-down and data-path reset start set
	localparam logic [15:0] CR1_RESET = 16'h0006;
	localparam logic [15:0] CR2_RESET = 16'h0000;
	localparam logic [15:0] CR1_WMASK = 16'hFFDF;

	// ****************************************
	// First control register fields
	// ****************************************
	localparam int NIBBLE_ALIGN_OFF_BIT   = 15;
	localparam int PAYLOAD_AIS_HI         = 14;
	localparam int PAYLOAD_AIS_LO         = 12;
	localparam int LINE_AIS_HI            = 11;
	localparam int LINE_AIS_LO            = 10;
	localparam int BIT_ERROR_TEST_ON_BIT  = 9;
	localparam int HDLC_ROUTE_SEL_BIT     = 8;
	localparam int MANUAL_ERR_INSERT_BIT  = 7;
	localparam int ERR_INSERT_SOURCE_BIT  = 6;
	localparam int PERF_UPDATE_SOURCE_BIT = 4;
	localparam int PERF_UPDATE_TRIG_BIT   = 3;
	localparam int PORT_POWER_DOWN_BIT    = 2;
	localparam int DATAPATH_RESET_BIT     = 1;
	localparam int PORT_RESET_BIT         = 0;

	// ****************************************
	// Second control register fields
	// ****************************************
	localparam int TX_LINE_OUT_ON_BIT     = 15;
	localparam int TX_DRIVER_HIZ_BIT      = 14;
	localparam int RX_MONITOR_GAIN_BIT    = 13;
	localparam int TX_LINE_BUILDOUT_BIT   = 12;
	localparam int CELL_VERIFY_EIGHT_BIT  = 11;
	localparam int PORT_IFACE_MODE_HI     = 10;
	localparam int PORT_IFACE_MODE_LO     = 8;
	localparam int CELL_DELIN_IN_PLCP_BIT = 7;
	localparam int CELL_PROC_SELECT_BIT   = 6;
	localparam int FRAMING_MODE_HI        = 5;
	localparam int FRAMING_MODE_LO        = 0;

	// Status register field
	localparam int PERF_UPDATE_DONE_BIT   = 0;

	// ****************************************
	// Counts and times
	// ****************************************
	localparam logic [3:0] CELL_VERIFY_SIX   = 4'h6;
	localparam logic [3:0] CELL_VERIFY_EIGHT = 4'h8;
	localparam logic [2:0] IFACE_MODE_OFF    = 3'h0;
	localparam int         CORE_CLK_MHZ      = 200;
	localparam int         RESET_MIN_NS      = 100;
	localparam int         RESET_HOLD_CYCLES = (RESET_MIN_NS * CORE_CLK_MHZ + 999) / 1000;

endpackage

// *** verif/testbench.sv ***
// Self-checking bench for the per-port control register pair.
// Assumes the design package is compiled first and one 200 MHz core clock.
`timescale 1ns/1ps
`default_nettype none

module testbench
	import port_ctrl_pkg::*;
;
	logic              core_clk;
	logic              rst_n;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wr_data;
	logic              wr_en;
	logic              rd_en;
	logic [DATA_W-1:0] rd_data;
	logic              global_reset, global_err_insert_src, global_perf_update_src;
	logic              plcp_mode, pos_bus_mode, rx_fifo_reset;
	logic              tx_line_clk_in, tx_pos_in, tx_neg_in, tx_liu_pos_in, tx_liu_neg_in;
	logic              nibble_align_off, bit_error_test_on, hdlc_to_plcp;
	logic [2:0]        payload_ais_sel, port_iface_mode;
	logic [1:0]        line_ais_sel;
	logic              err_insert_pulse, perf_update_pulse, port_clk_en;
	logic              datapath_reset_out, port_regs_reset, rx_to_cell_proc;
	logic              tx_line_clk_out, tx_pos_out, tx_neg_out;
	logic              tx_line_pos_out, tx_line_pos_oe, tx_line_neg_out, tx_line_neg_oe;
	logic              rx_monitor_gain, tx_line_buildout, delin_in_plcp, cell_processing;
	logic [3:0]        cell_verify_count;
	logic [5:0]        framing_mode_sel;
	int                mismatches = 0;
	int                num_checks = 0;

	port_control_registers uut (.core_clk, .rst_n, .addr, .wr_data, .wr_en, .rd_en, .rd_data,
		.global_reset, .global_err_insert_src, .global_perf_update_src, .plcp_mode,
		.pos_bus_mode, .rx_fifo_reset, .tx_line_clk_in, .tx_pos_in, .tx_neg_in,
		.tx_liu_pos_in, .tx_liu_neg_in, .nibble_align_off, .payload_ais_sel, .line_ais_sel,
		.bit_error_test_on, .hdlc_to_plcp, .err_insert_pulse, .perf_update_pulse,
		.port_clk_en, .datapath_reset_out, .port_regs_reset, .rx_to_cell_proc,
		.tx_line_clk_out, .tx_pos_out, .tx_neg_out, .tx_line_pos_out, .tx_line_pos_oe,
		.tx_line_neg_out, .tx_line_neg_oe, .rx_monitor_gain, .tx_line_buildout,
		.cell_verify_count, .delin_in_plcp, .cell_processing, .port_iface_mode,
		.framing_mode_sel);

	initial core_clk = 1'b0;
	always #2.5 core_clk = ~core_clk;

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	// Samples one step after the edge so registered outputs have landed
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	task automatic wr(input logic [11:0] a, input logic [15:0] d);
		@(posedge core_clk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge core_clk);
		wr_en <= 1'b0;
	endtask

	task automatic rchk(input logic [11:0] a, input logic [15:0] exp, input string what);
		@(posedge core_clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge core_clk);
		rd_en <= 1'b0;
		#1;
		chk(rd_data, exp, what);
	endtask

	task automatic pulses(input bit which, input int n, output int cnt);
		cnt = 0;
		repeat (n) begin
			tick(1);
			if ((which ? err_insert_pulse : perf_update_pulse) === 1'b1) cnt++;
		end
	endtask

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset;
		rchk(PORT_CONTROL_ONE_OFS, CR1_RESET, "cr1 reset");
		tick(1);
		chk(rd_data, 16'h0000, "read data after its cycle");
		rchk(PORT_CONTROL_TWO_OFS, CR2_RESET, "cr2 reset");
		wr(PORT_STATUS_OFS, 16'hFFFF);
		wr(12'h044, 16'hFFFF);
		rchk(PORT_STATUS_OFS, 16'h0000, "status read only");
		rchk(12'h044, 16'h0000, "unmapped read");
		chk(port_clk_en, 1'b0, "clocks stopped");
		chk(datapath_reset_out, 1'b1, "datapath reset");
		chk(cell_verify_count, CELL_VERIFY_SIX, "verify six");
		chk(tx_line_pos_oe, 1'b0, "line iface off");
		chk(framing_mode_sel, 6'h00, "framing reset");
		$display("test reset done");
	endtask

	task automatic t_fields;
		int cnt;
		wr(PORT_CONTROL_ONE_OFS, 16'hDB20);
		cnt = 0;
		while (datapath_reset_out === 1'b1 && cnt < 40) begin
			tick(1);
			cnt++;
		end
		chk(16'(cnt >= RESET_HOLD_CYCLES - 3), 16'h0001, "stretch length");
		chk(datapath_reset_out, 1'b0, "stretch end");
		rchk(PORT_CONTROL_ONE_OFS, 16'hDB00, "cr1 readback");
		chk(nibble_align_off, 1'b1, "nibble align off");
		chk(payload_ais_sel, 3'h5, "payload ais");
		chk(line_ais_sel, 2'h2, "line ais");
		chk(bit_error_test_on, 1'b1, "test logic on");
		chk(hdlc_to_plcp, 1'b0, "hdlc outside plcp");
		chk(rx_to_cell_proc, 1'b1, "rx flows");
		chk(port_clk_en, 1'b1, "clocks run");
		@(posedge core_clk);
		plcp_mode <= 1'b1;
		rx_fifo_reset <= 1'b1;
		tick(3);
		chk(hdlc_to_plcp, 1'b1, "hdlc in plcp");
		chk(rx_to_cell_proc, 1'b0, "rx fifo reset");
		@(posedge core_clk);
		plcp_mode <= 1'b0;
		rx_fifo_reset <= 1'b0;
		wr(PORT_CONTROL_ONE_OFS, 16'h0000);
		tick(2);
		chk(nibble_align_off, 1'b0, "nibble align on");
		chk(bit_error_test_on, 1'b0, "test logic off");
		$display("test fields done");
	endtask

	// which = 0: monitor update, which = 1: manual error insertion
	task automatic t_trigger(input bit which);
		int c;
		logic [15:0] trig;
		logic [15:0] src;
		trig = which ? 16'h0080 : 16'h0008;
		src = which ? 16'h0040 : 16'h0010;
		wr(PORT_CONTROL_ONE_OFS, trig);
		pulses(which, 6, c);
		chk(16'(c), 16'h0001, "port trigger");
		if (!which) begin
			rchk(PORT_STATUS_OFS, 16'h0001, "done held");
		end
		wr(PORT_CONTROL_ONE_OFS, 16'h0000);
		rchk(PORT_STATUS_OFS, 16'h0000, "done cleared");
		@(posedge core_clk);
		if (which) global_err_insert_src <= 1'b1;
		else global_perf_update_src <= 1'b1;
		pulses(which, 6, c);
		chk(16'(c), 16'h0000, "global ignored");
		@(posedge core_clk);
		global_err_insert_src <= 1'b0;
		global_perf_update_src <= 1'b0;
		wr(PORT_CONTROL_ONE_OFS, src);
		wr(PORT_CONTROL_ONE_OFS, src | trig);
		pulses(which, 6, c);
		chk(16'(c), 16'h0000, "port bit ignored");
		@(posedge core_clk);
		if (which) global_err_insert_src <= 1'b1;
		else global_perf_update_src <= 1'b1;
		pulses(which, 6, c);
		chk(16'(c), 16'h0001, "global trigger");
		@(posedge core_clk);
		global_err_insert_src <= 1'b0;
		global_perf_update_src <= 1'b0;
		wr(PORT_CONTROL_ONE_OFS, 16'h0000);
		$display("test trigger %0d done", which);
	endtask

	task automatic t_line;
		@(posedge core_clk);
		{tx_line_clk_in, tx_pos_in, tx_neg_in, tx_liu_pos_in, tx_liu_neg_in} <= 5'h1F;
		tick(2);
		chk({tx_line_clk_out, tx_pos_out, tx_neg_out}, 3'h0, "line forced low");
		wr(PORT_CONTROL_TWO_OFS, 16'h8100);
		tick(2);
		chk({tx_line_clk_out, tx_pos_out, tx_neg_out}, 3'h7, "line enabled");
		chk({tx_line_pos_out, tx_line_pos_oe, tx_line_neg_out, tx_line_neg_oe}, 4'hF,
			"driver on");
		wr(PORT_CONTROL_TWO_OFS, 16'h4100);
		tick(2);
		chk({tx_line_pos_oe, tx_line_neg_oe}, 2'h0, "driver hiz");
		wr(PORT_CONTROL_TWO_OFS, 16'h0100);
		wr(PORT_CONTROL_ONE_OFS, 16'h0004);
		tick(2);
		chk({tx_line_pos_oe, tx_line_neg_oe, port_clk_en}, 3'h0, "port down");
		wr(PORT_CONTROL_ONE_OFS, 16'h0000);
		$display("test line done");
	endtask

	task automatic t_modes;
		@(posedge core_clk);
		pos_bus_mode <= 1'b1;
		wr(PORT_CONTROL_TWO_OFS, 16'h3BFF);
		rchk(PORT_CONTROL_TWO_OFS, 16'h3BFF, "cr2 readback");
		chk({rx_monitor_gain, tx_line_buildout}, 2'h3, "monitor and buildout on");
		chk(cell_verify_count, CELL_VERIFY_EIGHT, "verify eight");
		chk(port_iface_mode, 3'h3, "iface mode");
		chk(framing_mode_sel, 6'h3F, "framing mode");
		chk(delin_in_plcp, 1'b0, "delin outside plcp");
		chk(cell_processing, 1'b1, "cell proc");
		wr(PORT_CONTROL_TWO_OFS, 16'h0000);
		tick(2);
		chk(cell_processing, 1'b0, "packet proc");
		chk(cell_verify_count, CELL_VERIFY_SIX, "verify six");
		chk({rx_monitor_gain, tx_line_buildout}, 2'h0, "monitor and buildout off");
		@(posedge core_clk);
		plcp_mode <= 1'b1;
		wr(PORT_CONTROL_TWO_OFS, 16'h0080);
		tick(2);
		chk(delin_in_plcp, 1'b1, "delin in plcp");
		chk(cell_processing, 1'b1, "plcp forces cells");
		@(posedge core_clk);
		plcp_mode <= 1'b0;
		pos_bus_mode <= 1'b0;
		$display("test modes done");
	endtask

	task automatic t_soft;
		wr(PORT_CONTROL_TWO_OFS, 16'h8123);
		wr(PORT_CONTROL_ONE_OFS, 16'hDB01);
		tick(RESET_HOLD_CYCLES);
		chk(port_regs_reset, 1'b1, "soft reset on");
		chk(datapath_reset_out, 1'b1, "soft reset datapath");
		rchk(PORT_CONTROL_ONE_OFS, CR1_RESET | 16'h0001, "cr1 kept bit");
		rchk(PORT_CONTROL_TWO_OFS, 16'h0000, "cr2 cleared");
		wr(PORT_CONTROL_ONE_OFS, 16'h0000);
		tick(2);
		chk(port_regs_reset, 1'b0, "soft reset off");
		wr(PORT_CONTROL_TWO_OFS, 16'h8123);
		global_reset <= 1'b1;
		tick(RESET_HOLD_CYCLES);
		chk(port_regs_reset, 1'b1, "global reset on");
		@(posedge core_clk);
		global_reset <= 1'b0;
		rchk(PORT_CONTROL_TWO_OFS, 16'h0000, "cr2 global cleared");
		rchk(PORT_CONTROL_ONE_OFS, CR1_RESET, "cr1 global reset");
		$display("test soft reset done");
	endtask

	initial begin
		rst_n = 1'b0;
		{addr, wr_data, wr_en, rd_en} = '0;
		{global_reset, global_err_insert_src, global_perf_update_src} = '0;
		{plcp_mode, pos_bus_mode, rx_fifo_reset} = '0;
		{tx_line_clk_in, tx_pos_in, tx_neg_in, tx_liu_pos_in, tx_liu_neg_in} = '0;
		repeat (8) @(posedge core_clk);
		rst_n <= 1'b1;
		t_reset();
		t_fields();
		t_trigger(1'b0);
		t_trigger(1'b1);
		t_line();
		t_modes();
		t_soft();
		report_and_stop();
	end

	// The tests need some 230 cycles; this leaves a wide margin
	initial begin
		#50000;
		mismatches++;
		report_and_stop();
	end

endmodule // testbench

`default_nettype wire
